//--- rtl/card_spi_cmd_response_unit.v
// Card command interpreter and response builder for the serial link.
//
// Overview of operation
// - Multiple-block write takes blocks until stop token or preset count.
// - Card-data program command has no argument; answers with busy status.
// - Protect set and clear change the addressed group's bit; busy status.
// - Protect query sends 32 protection bits then 16 CRC bits as data.
// - Lowest bit is the first group; groups out of range read zero.
// - Erase start and end commands latch first and last group addresses.
// - Erase command erases the tagged range and answers with busy status.
// - Lock command takes one data block of current length; busy status.
// - Operating-conditions read returns the register in a five-byte reply.
// - CRC control enables checking when argument bit 0 is one.
// - Default block length applies until a new length is set.
// - Writes may not cross block boundaries unless misalignment permitted.
// - Every response byte leaves most significant bit first.
// - Every command, status read included, gets a status byte with MSB zero.
// - Idle flag is set while initialisation still runs.
// - Erase-reset flag marks an erase sequence cancelled by another command.
// - Illegal-command and command-CRC flags report bad index or checksum.
// - Erase-sequence flag marks erase commands out of order.
// - Address flag marks an address misaligned to the block length.
// - Parameter flag marks an argument outside the card's range.
// - Busy status sends zero bytes while busy, non-zero when ready.
// - Status read is answered with a two-byte status response.
`include "card_spi_consts.vh"

module card_spi_cmd_response_unit (
	input wire clk,
	input wire resetn,
	input wire spi_sclk,
	input wire spi_cs_n,
	input wire spi_mosi,
	output wire spi_miso,
	output reg spi_miso_oe_r,
	input wire init_active,
	input wire mem_busy,
	input wire [7:0] ext_status2,
	input wire [15:0] preset_blocks,
	input wire blk_len_load,
	input wire [11:0] blk_len_value,
	input wire write_misalign_permit,
	output reg [7:0] wr_data_r,
	output reg wr_valid_r,
	output reg [31:0] wr_addr_r,
	output reg lock_data_r,
	output reg csd_program_r,
	output reg erase_go_r,
	output reg [31:0] erase_first_r,
	output reg [31:0] erase_last_r,
	output reg crc_enable_r,
	output reg cmd_fwd_r,
	output reg [5:0] cmd_index_r,
	output reg [31:0] cmd_arg_r
);

	localparam ST_CMD = 5'b00001;
	localparam ST_RESP = 5'b00010;
	localparam ST_BUSY = 5'b00100;
	localparam ST_TOKEN = 5'b01000;
	localparam ST_DATA = 5'b10000;

	wire sclk_rise;
	wire sclk_fall;
	wire cs_n_s;
	wire mosi_s;
	wire rx_valid;
	wire [7:0] rx_byte;
	wire [47:0] frame;
	wire [5:0] idx;
	wire [31:0] arg;

	reg [4:0] st_r;
	reg [4:0] follow_r;
	reg [4:0] busy_next_r;
	reg [2:0] byte_cnt_r;
	reg [39:0] frame_r;
	reg [7:0] tx_byte_r;
	reg [71:0] buf_r;
	reg [3:0] resp_cnt_r;
	reg [3:0] busy_cnt_r;
	reg [12:0] dcnt_r;
	reg [15:0] blocks_r;
	reg multi_r;
	reg [11:0] blk_len_r;
	reg [1:0] ers_pend_r;
	reg [255:0] prot_r;

	reg is_illegal;
	reg crc_bad;
	reg ers_rst;
	reg seq_err;
	reg addr_err;
	reg par_err;
	reg fwd;
	reg cmd_ok;
	reg [7:0] r1;
	reg [71:0] buf_nxt;
	reg [3:0] cnt_nxt;
	reg [4:0] follow_nxt;
	reg [31:0] prot_word;
	reg [31:0] grp;
	reg [31:0] grp_base;
	integer i;

	link_sync u_sync (
		.clk(clk),
		.resetn(resetn),
		.sclk_pin(spi_sclk),
		.cs_n_pin(spi_cs_n),
		.mosi_pin(spi_mosi),
		.sclk_rise(sclk_rise),
		.sclk_fall(sclk_fall),
		.cs_n_sync(cs_n_s),
		.mosi_sync(mosi_s)
	);

	byte_link u_link (
		.clk(clk),
		.resetn(resetn),
		.sclk_rise(sclk_rise),
		.sclk_fall(sclk_fall),
		.cs_n_sync(cs_n_s),
		.mosi_sync(mosi_s),
		.tx_byte(tx_byte_r),
		.rx_byte(rx_byte),
		.rx_valid(rx_valid),
		.miso(spi_miso)
	);

	// Serial CRC7 over the first forty bits of a command frame.
	function [6:0] crc7;
		input [39:0] d;
		integer k;
		reg [6:0] c;
		reg fb;
		begin
			c = 7'h00;
			for (k = 39; k >= 0; k = k - 1) begin
				fb = d[k] ^ c[6];
				c = {c[5:0], 1'b0};
				if (fb) begin
					c = c ^ `CRC7_POLY;
				end
			end
			crc7 = c;
		end
	endfunction

	// Serial CRC16 over the protection payload.
	function [15:0] crc16;
		input [31:0] d;
		integer k;
		reg [15:0] c;
		reg fb;
		begin
			c = 16'h0000;
			for (k = 31; k >= 0; k = k - 1) begin
				fb = d[k] ^ c[15];
				c = {c[14:0], 1'b0};
				if (fb) begin
					c = c ^ `CRC16_POLY;
				end
			end
			crc16 = c;
		end
	endfunction

	// The frame as it stands once its sixth byte has arrived.
	assign frame = {frame_r, rx_byte};
	assign idx = frame[45:40];
	assign arg = frame[39:8];

	// Protection bits of 32 groups from the addressed one upward.
	always @* begin
		grp_base = arg >> `WP_GRP_SHIFT;
		prot_word = 32'h00000000;
		grp = 32'h00000000;
		for (i = 0; i < 32; i = i + 1) begin
			grp = grp_base + i;
			if (grp < `WP_GROUPS) begin
				prot_word[i] = prot_r[grp[7:0]];
			end
		end
	end

	// Decode of a complete command: flags, reply bytes and what follows.
	always @* begin
		is_illegal = (idx == `CMD_RSV_A) || (idx == `CMD_RSV_B) ||
			(idx == `CMD_RSV_C) || (idx == `CMD_RSV_D) ||
			(idx == `CMD_RSV_E) ||
			((idx >= `CMD_RSV_LO) && (idx <= `CMD_RSV_HI));
		if (((idx == `CMD_PROT_SET) || (idx == `CMD_PROT_CLR) ||
			(idx == `CMD_PROT_QRY)) && !`WP_SUPPORTED) begin
			is_illegal = 1'b1;
		end
		crc_bad = crc_enable_r && (crc7(frame[47:8]) != frame[7:1]);
		ers_rst = (ers_pend_r != `ERS_NONE) && (idx != `CMD_ERS_FIRST) &&
			(idx != `CMD_ERS_LAST) && (idx != `CMD_ERASE) &&
			(idx != `CMD_STATUS);
		seq_err = ((idx == `CMD_ERS_LAST) && (ers_pend_r != `ERS_FIRST)) ||
			((idx == `CMD_ERASE) && (ers_pend_r != `ERS_BOTH));
		addr_err = (idx == `CMD_WR_MULTI) && !write_misalign_permit &&
			((arg[11:0] & (blk_len_r - 12'h001)) != 12'h000);
		par_err = ((idx == `CMD_WR_MULTI) || (idx == `CMD_PROT_SET) ||
			(idx == `CMD_PROT_CLR) || (idx == `CMD_PROT_QRY) ||
			(idx == `CMD_ERS_FIRST) || (idx == `CMD_ERS_LAST)) &&
			(arg >= `CARD_CAPACITY);
		r1 = 8'h00;
		r1[`R1_IDLE] = init_active;
		r1[`R1_ERS_RST] = ers_rst;
		r1[`R1_ILLEGAL] = is_illegal;
		r1[`R1_CRC] = crc_bad;
		r1[`R1_ERS_SEQ] = seq_err;
		r1[`R1_ADDR] = addr_err;
		r1[`R1_PARAM] = par_err;
		cmd_ok = !(is_illegal || crc_bad || seq_err || addr_err || par_err);
		fwd = cmd_ok && (idx < `CMD_WR_MULTI) && (idx != `CMD_STATUS);
		buf_nxt = {r1, 64'h0};
		cnt_nxt = 4'h1;
		follow_nxt = ST_CMD;
		if (cmd_ok) begin
			case (idx)
				`CMD_STATUS: begin
					buf_nxt = {r1, ext_status2, 56'h0};
					cnt_nxt = 4'h2;
				end
				`CMD_OPCOND: begin
					buf_nxt = {r1, `OCR_VALUE, 32'h0};
					cnt_nxt = 4'h5;
				end
				`CMD_PROT_QRY: begin
					buf_nxt = {r1, `BYTE_IDLE, `TOK_START_SINGLE, prot_word,
						crc16(prot_word)};
					cnt_nxt = 4'h9;
				end
				`CMD_PROG_CSD, `CMD_PROT_SET, `CMD_PROT_CLR,
				`CMD_ERASE: begin
					follow_nxt = ST_BUSY;
				end
				`CMD_WR_MULTI, `CMD_LOCK: begin
					follow_nxt = ST_TOKEN;
				end
				default: begin
					follow_nxt = ST_CMD;
				end
			endcase
		end
	end

	// Pin enable follows chip select so the pin is free outside frames.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			spi_miso_oe_r <= 1'b0;
		end else begin
			spi_miso_oe_r <= !cs_n_s;
		end
	end

	// Block length: the default holds until the adjoining logic loads one.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			blk_len_r <= `DEF_BLOCK_LEN;
		end else if (blk_len_load) begin
			blk_len_r <= blk_len_value;
		end
	end

	// Byte-paced sequencer: each received byte moves the reply one byte on.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= ST_CMD;
			follow_r <= ST_CMD;
			busy_next_r <= ST_CMD;
			byte_cnt_r <= 3'h0;
			frame_r <= 40'h0;
			tx_byte_r <= `BYTE_IDLE;
			buf_r <= 72'h0;
			resp_cnt_r <= 4'h0;
			busy_cnt_r <= 4'h0;
			dcnt_r <= 13'h0;
			blocks_r <= 16'h0;
			multi_r <= 1'b0;
			ers_pend_r <= `ERS_NONE;
			prot_r <= 256'h0;
			wr_data_r <= 8'h00;
			wr_valid_r <= 1'b0;
			wr_addr_r <= 32'h0;
			lock_data_r <= 1'b0;
			csd_program_r <= 1'b0;
			erase_go_r <= 1'b0;
			erase_first_r <= 32'h0;
			erase_last_r <= 32'h0;
			crc_enable_r <= 1'b0;
			cmd_fwd_r <= 1'b0;
			cmd_index_r <= 6'h00;
			cmd_arg_r <= 32'h0;
		end else begin
			wr_valid_r <= 1'b0;
			csd_program_r <= 1'b0;
			erase_go_r <= 1'b0;
			cmd_fwd_r <= 1'b0;
			if (cs_n_s) begin
				st_r <= ST_CMD;
				byte_cnt_r <= 3'h0;
				tx_byte_r <= `BYTE_IDLE;
			end else if (rx_valid) begin
				case (st_r)
					ST_CMD: begin
						if (byte_cnt_r == 3'h0 && rx_byte[7:6] != `CMD_PREFIX) begin
							tx_byte_r <= `BYTE_IDLE;
						end else if (byte_cnt_r != `FRAME_LAST) begin
							frame_r <= frame[39:0];
							byte_cnt_r <= byte_cnt_r + 3'h1;
						end else begin
							byte_cnt_r <= 3'h0;
							tx_byte_r <= `BYTE_IDLE;
							buf_r <= buf_nxt;
							resp_cnt_r <= cnt_nxt;
							follow_r <= follow_nxt;
							busy_cnt_r <= `BUSY_BYTES;
							busy_next_r <= ST_CMD;
							st_r <= ST_RESP;
							cmd_index_r <= idx;
							cmd_arg_r <= arg;
							cmd_fwd_r <= fwd;
							if (!crc_bad && ers_rst) begin
								ers_pend_r <= `ERS_NONE;
							end
							if (cmd_ok) begin
								case (idx)
									`CMD_WR_MULTI: begin
										wr_addr_r <= arg;
										multi_r <= 1'b1;
										blocks_r <= 16'h0;
										lock_data_r <= 1'b0;
									end
									`CMD_LOCK: begin
										wr_addr_r <= 32'h0;
										multi_r <= 1'b0;
										lock_data_r <= 1'b1;
									end
									`CMD_PROG_CSD: begin
										csd_program_r <= 1'b1;
									end
									`CMD_PROT_SET: begin
										prot_r[arg[23:16]] <= 1'b1;
									end
									`CMD_PROT_CLR: begin
										prot_r[arg[23:16]] <= 1'b0;
									end
									`CMD_ERS_FIRST: begin
										erase_first_r <= arg;
										ers_pend_r <= `ERS_FIRST;
									end
									`CMD_ERS_LAST: begin
										erase_last_r <= arg;
										ers_pend_r <= `ERS_BOTH;
									end
									`CMD_ERASE: begin
										erase_go_r <= 1'b1;
										ers_pend_r <= `ERS_NONE;
									end
									`CMD_CRC_CTL: begin
										crc_enable_r <= arg[0];
									end
									default: begin
										multi_r <= multi_r;
									end
								endcase
							end
						end
					end
					ST_RESP: begin
						tx_byte_r <= buf_r[71:64];
						buf_r <= {buf_r[63:0], 8'h00};
						resp_cnt_r <= resp_cnt_r - 4'h1;
						if (resp_cnt_r == 4'h1) begin
							st_r <= follow_r;
						end
					end
					ST_BUSY: begin
						if (busy_cnt_r != 4'h0 || mem_busy) begin
							tx_byte_r <= `BYTE_BUSY;
							if (busy_cnt_r != 4'h0) begin
								busy_cnt_r <= busy_cnt_r - 4'h1;
							end
						end else begin
							tx_byte_r <= `BYTE_IDLE;
							st_r <= busy_next_r;
						end
					end
					ST_TOKEN: begin
						tx_byte_r <= `BYTE_IDLE;
						dcnt_r <= 13'h0;
						if (multi_r && rx_byte == `TOK_START_MULTI) begin
							st_r <= ST_DATA;
						end else if (multi_r && rx_byte == `TOK_STOP) begin
							// Busy starts at once so the host never reads ready early.
							tx_byte_r <= `BYTE_BUSY;
							busy_cnt_r <= `BUSY_BYTES - 4'h1;
							busy_next_r <= ST_CMD;
							st_r <= ST_BUSY;
						end else if (!multi_r && rx_byte == `TOK_START_SINGLE) begin
							st_r <= ST_DATA;
						end
					end
					ST_DATA: begin
						tx_byte_r <= `BYTE_IDLE;
						dcnt_r <= dcnt_r + 13'h1;
						if (dcnt_r < {1'b0, blk_len_r}) begin
							wr_data_r <= rx_byte;
							wr_valid_r <= 1'b1;
						end
						if (dcnt_r == {1'b0, blk_len_r} + 13'h1) begin
							tx_byte_r <= `DRESP_OK;
							blocks_r <= blocks_r + 16'h1;
							wr_addr_r <= wr_addr_r + {20'h0, blk_len_r};
							busy_cnt_r <= `BUSY_BYTES;
							st_r <= ST_BUSY;
							lock_data_r <= 1'b0;
							if (multi_r && !(preset_blocks != 16'h0 &&
								blocks_r + 16'h1 == preset_blocks)) begin
								busy_next_r <= ST_TOKEN;
							end else begin
								busy_next_r <= ST_CMD;
							end
						end
					end
					default: begin
						st_r <= ST_CMD;
					end
				endcase
			end
		end
	end

endmodule // card_spi_cmd_response_unit

//--- rtl/card_spi_consts.vh
// Named constants shared by the card command and response logic.
`ifndef CARD_SPI_CONSTS_VH
`define CARD_SPI_CONSTS_VH

// Command indices handled by this block.
`define CMD_STATUS 6'h0D
`define CMD_WR_MULTI 6'h19
`define CMD_PROG_CSD 6'h1B
`define CMD_PROT_SET 6'h1C
`define CMD_PROT_CLR 6'h1D
`define CMD_PROT_QRY 6'h1E
`define CMD_ERS_FIRST 6'h23
`define CMD_ERS_LAST 6'h24
`define CMD_ERASE 6'h26
`define CMD_LOCK 6'h2A
`define CMD_OPCOND 6'h3A
`define CMD_CRC_CTL 6'h3B
// Unsupported and reserved indices.
`define CMD_RSV_A 6'h1A
`define CMD_RSV_B 6'h1F
`define CMD_RSV_C 6'h27
`define CMD_RSV_D 6'h28
`define CMD_RSV_E 6'h29
`define CMD_RSV_LO 6'h2B
`define CMD_RSV_HI 6'h39

// Command frame layout.
`define CMD_PREFIX 2'h1
`define FRAME_LAST 3'h5

// Tokens and filler bytes.
`define TOK_START_SINGLE 8'hFE
`define TOK_START_MULTI 8'hFC
`define TOK_STOP 8'hFD
`define DRESP_OK 8'h05
`define BYTE_IDLE 8'hFF
`define BYTE_BUSY 8'h00

// Bit positions of the one-byte status response.
`define R1_IDLE 0
`define R1_ERS_RST 1
`define R1_ILLEGAL 2
`define R1_CRC 3
`define R1_ERS_SEQ 4
`define R1_ADDR 5
`define R1_PARAM 6

// Card geometry, defaults and register contents.
`define DEF_BLOCK_LEN 12'h200
`define CARD_CAPACITY 32'h01000000
`define WP_GRP_SHIFT 5'h10
`define WP_GROUPS 32'h00000100
`define WP_SUPPORTED 1'b1
`define OCR_VALUE 32'h00FF8000
`define BUSY_BYTES 4'h2

// Erase tagging progress.
`define ERS_NONE 2'h0
`define ERS_FIRST 2'h1
`define ERS_BOTH 2'h2

// Checksum polynomials.
`define CRC7_POLY 7'h09
`define CRC16_POLY 16'h1021

`endif

//--- rtl/link_sync.v
// Two-stage synchronisers for the serial pins and clock edge detection.
`include "card_spi_consts.vh"

module link_sync (
	input wire clk,
	input wire resetn,
	input wire sclk_pin,
	input wire cs_n_pin,
	input wire mosi_pin,
	output wire sclk_rise,
	output wire sclk_fall,
	output wire cs_n_sync,
	output wire mosi_sync
);

	wire [2:0] pin_in;
	wire [2:0] pin_s;
	reg sclk_d_r;

	assign pin_in = {cs_n_pin, mosi_pin, sclk_pin};

	// One two-flop chain per pin; the first stage feeds only the second.
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_sync
			reg s1_r;
			reg s2_r;
			always @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					s1_r <= (i == 2) ? 1'b1 : 1'b0;
					s2_r <= (i == 2) ? 1'b1 : 1'b0;
				end else begin
					s1_r <= pin_in[i];
					s2_r <= s1_r;
				end
			end
			assign pin_s[i] = s2_r;
		end
	endgenerate

	// A delayed copy of the synchronised clock gives its edges.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= pin_s[0];
		end
	end

	assign sclk_rise = pin_s[0] & ~sclk_d_r;
	assign sclk_fall = ~pin_s[0] & sclk_d_r;
	assign mosi_sync = pin_s[1];
	assign cs_n_sync = pin_s[2];

endmodule // link_sync

//--- rtl/byte_link.v
// Full-duplex byte shifter: receives on rising and sends on falling edges.
`include "card_spi_consts.vh"

module byte_link (
	input wire clk,
	input wire resetn,
	input wire sclk_rise,
	input wire sclk_fall,
	input wire cs_n_sync,
	input wire mosi_sync,
	input wire [7:0] tx_byte,
	output wire [7:0] rx_byte,
	output reg rx_valid,
	output reg miso
);

	reg [2:0] bit_cnt_r;
	reg [7:0] rx_sh_r;
	reg [7:0] tx_sh_r;
	reg load_r;

	assign rx_byte = rx_sh_r;

	// Bits are taken MSB first; the next byte to send is loaded one
	// cycle after a byte completes, well before the following fall.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bit_cnt_r <= 3'h0;
			rx_sh_r <= 8'h00;
			tx_sh_r <= `BYTE_IDLE;
			rx_valid <= 1'b0;
			load_r <= 1'b0;
			miso <= 1'b1;
		end else if (cs_n_sync) begin
			bit_cnt_r <= 3'h0;
			tx_sh_r <= `BYTE_IDLE;
			rx_valid <= 1'b0;
			load_r <= 1'b0;
			miso <= 1'b1;
		end else begin
			rx_valid <= sclk_rise && (bit_cnt_r == 3'h7);
			load_r <= rx_valid;
			if (sclk_rise) begin
				rx_sh_r <= {rx_sh_r[6:0], mosi_sync};
				bit_cnt_r <= bit_cnt_r + 3'h1;
			end
			if (load_r) begin
				tx_sh_r <= tx_byte;
			end else if (sclk_fall) begin
				miso <= tx_sh_r[7];
				tx_sh_r <= {tx_sh_r[6:0], 1'b1};
			end
		end
	end

endmodule // byte_link

//--- testbench/spi_host_model.sv
// Host side serial master model that clocks bytes through the card link.
module spi_host_model (
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF = 24;
	// The link clock rests low and only runs inside a byte.
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b1;
	end
	// Data leaves on the falling edge and is read back on the rising edge.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi = tx[i];
			#HALF sclk = 1'b1;
			rx[i] = miso;
			#HALF sclk = 1'b0;
		end
	endtask
	// Selects the card and leaves it time to see the select.
	task automatic open_frame();
		cs_n = 1'b0;
		#(2 * HALF);
	endtask
	// Deselects; the data line is flipped so a stale level never persists.
	task automatic close_frame();
		#HALF;
		cs_n = 1'b1;
		mosi = ~mosi;
		#(4 * HALF);
	endtask
endmodule // spi_host_model

//--- testbench/card_spi_cmd_response_unit_asserts.sv
// Concurrent checks on the ports of the card command unit.
`include "card_spi_consts.vh"
module card_spi_checker (
	input wire clk,
	input wire resetn,
	input wire spi_cs_n,
	input wire spi_miso,
	input wire spi_miso_oe_r,
	input wire wr_valid_r,
	input wire lock_data_r,
	input wire csd_program_r,
	input wire erase_go_r,
	input wire [31:0] erase_first_r,
	input wire [31:0] erase_last_r,
	input wire crc_enable_r,
	input wire [5:0] cmd_index_r,
	input wire [31:0] cmd_arg_r
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Strobes last one cycle and belong to the command that caused them.
	property p_csd_pulse;
		csd_program_r |-> cmd_index_r == `CMD_PROG_CSD ##1 !csd_program_r;
	endproperty
	a_csd_pulse: assert property (p_csd_pulse) else $error("bad program strobe");
	property p_erase_pulse;
		erase_go_r |-> cmd_index_r == `CMD_ERASE ##1 !erase_go_r;
	endproperty
	a_erase_pulse: assert property (p_erase_pulse) else $error("bad erase strobe");
	// Tagged addresses are already settled when the erase starts.
	property p_erase_tags;
		erase_go_r |-> $stable(erase_first_r) && $stable(erase_last_r);
	endproperty
	a_erase_tags: assert property (p_erase_tags) else $error("erase tags moved");
	// The checking switch only moves on its own command, to argument bit 0.
	property p_crc_ctl;
		$changed(crc_enable_r) |->
			cmd_index_r == `CMD_CRC_CTL && crc_enable_r == cmd_arg_r[0];
	endproperty
	a_crc_ctl: assert property (p_crc_ctl) else $error("bad checksum switch");
	// Each data strobe is followed by at least eight clocks without one, and strobes come only during block writes.
	property p_wr_gap;
		wr_valid_r |=> !wr_valid_r [*8];
	endproperty
	a_wr_gap: assert property (p_wr_gap) else $error("data strobes too close");
	property p_wr_cmd;
		wr_valid_r |-> lock_data_r || cmd_index_r == `CMD_WR_MULTI;
	endproperty
	a_wr_cmd: assert property (p_wr_cmd) else $error("data outside a write");
	// A deselected card leaves its data line high.
	property p_idle_high;
		spi_cs_n [*6] |-> spi_miso;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("line not idle");
	property p_oe_cs;
		$fell(spi_cs_n) |-> ##[2:4] spi_miso_oe_r;
	endproperty
	a_oe_cs: assert property (p_oe_cs) else $error("card did not drive");
	c_csd: cover property (csd_program_r);
	c_erase: cover property (erase_go_r);
	c_wr: cover property (wr_valid_r);
	c_crc_on: cover property ($rose(crc_enable_r));
endmodule // card_spi_checker

bind card_spi_cmd_response_unit card_spi_checker card_spi_checker_i (
	.clk(clk), .resetn(resetn), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
	.spi_miso_oe_r(spi_miso_oe_r), .wr_valid_r(wr_valid_r),
	.lock_data_r(lock_data_r), .csd_program_r(csd_program_r),
	.erase_go_r(erase_go_r), .erase_first_r(erase_first_r),
	.erase_last_r(erase_last_r), .crc_enable_r(crc_enable_r),
	.cmd_index_r(cmd_index_r), .cmd_arg_r(cmd_arg_r)
);

//--- testbench/card_spi_cmd_response_unit_bench.sv
// Self-checking bench for the card command unit behind a host model.
`include "card_spi_consts.vh"
module card_spi_cmd_response_unit_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic init_active = 1'b0;
	logic mem_busy = 1'b0;
	logic blk_len_load = 1'b0;
	logic write_misalign_permit = 1'b0;
	logic [7:0] ext_status2 = 8'h00;
	logic [11:0] blk_len_value = 12'h000;
	logic [15:0] preset_blocks = 16'h0000;
	int fwds = 0;
	wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_r;
	wire wr_valid_r, lock_data_r, csd_program_r, erase_go_r;
	wire crc_enable_r, cmd_fwd_r;
	wire [7:0] wr_data_r;
	wire [5:0] cmd_index_r;
	wire [31:0] wr_addr_r, erase_first_r, erase_last_r, cmd_arg_r;
	int mismatches = 0;
	int compares = 0;
	logic [31:0] seed = 32'h00009167;
	logic prot [0:255];
	logic [7:0] wq [$];
	logic [31:0] exp_addr, w;
	logic [7:0] b;

	always #2.5 clk = ~clk;

	card_spi_cmd_response_unit card_spi_cmd_response_unit_i (
		.clk(clk), .resetn(resetn), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.spi_miso_oe_r(spi_miso_oe_r), .init_active(init_active),
		.mem_busy(mem_busy), .ext_status2(ext_status2),
		.preset_blocks(preset_blocks), .blk_len_load(blk_len_load),
		.blk_len_value(blk_len_value),
		.write_misalign_permit(write_misalign_permit),
		.wr_data_r(wr_data_r), .wr_valid_r(wr_valid_r), .wr_addr_r(wr_addr_r),
		.lock_data_r(lock_data_r), .csd_program_r(csd_program_r),
		.erase_go_r(erase_go_r), .erase_first_r(erase_first_r),
		.erase_last_r(erase_last_r), .crc_enable_r(crc_enable_r),
		.cmd_fwd_r(cmd_fwd_r), .cmd_index_r(cmd_index_r), .cmd_arg_r(cmd_arg_r)
	);
	spi_host_model spi_host_model_i (
		.sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi), .miso(spi_miso)
	);

	// Pseudo-random bytes from a shift register.
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	function automatic logic [6:0] crc7(input logic [39:0] d);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 39; i >= 0; i--)
			c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? `CRC7_POLY : 7'h00);
		return c;
	endfunction
	function automatic logic [15:0] crc16(input logic [31:0] d);
		logic [15:0] c;
		c = 16'h0000;
		for (int i = 31; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((d[i] ^ c[15]) ? `CRC16_POLY : 16'h0000);
		return c;
	endfunction
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic x(input logic [7:0] t);
		spi_host_model_i.xfer(t, b);
	endtask
	task automatic close();
		spi_host_model_i.close_frame();
	endtask
	// Sends one command frame, checks the filler byte and the status byte.
	task automatic cmd(input logic [5:0] idx, input logic [31:0] arg,
		input logic bad, input logic [7:0] exp_r1);
		logic [39:0] f;
		f = {2'b01, idx, arg};
		spi_host_model_i.open_frame();
		for (int i = 4; i >= 0; i--)
			x(f[i * 8 +: 8]);
		x({crc7(f) ^ {bad, 6'h00}, 1'b1});
		x(8'hFF);
		chk(b, 8'hFF);
		x(8'hFF);
		chk(b, exp_r1);
	endtask
	// Host polls until a non-zero byte; hold lowers mem_busy after that many.
	task automatic busy(input int hold);
		int z;
		z = 0;
		x(8'hFF);
		for (int n = 0; n < 64 && b === 8'h00; n++) begin
			z++;
			if (z == hold)
				@(posedge clk) mem_busy <= 1'b0;
			x(8'hFF);
		end
		chk(b, 8'hFF);
		chk(hold == 0 ? z : (z >= hold), hold == 0 ? `BUSY_BYTES : 1);
		if (b === 8'h00)
			report_and_stop();
	endtask
	// Queries 32 protection bits from group g and checks payload and checksum.
	task automatic qry(input int g);
		logic [31:0] e;
		for (int k = 0; k < 32; k++)
			e[k] = (g + k < 256) ? prot[g + k] : 1'b0;
		cmd(`CMD_PROT_QRY, 32'(g) << 16, 1'b0, 8'h00);
		x(8'hFF);
		chk(b, 8'hFF);
		x(8'hFF);
		chk(b, `TOK_START_SINGLE);
		for (int i = 5; i >= 0; i--) begin
			x(8'hFF);
			if (i > 1)
				w[(i - 2) * 8 +: 8] = b;
			else
				exp_addr[i * 8 +: 8] = b;
		end
		chk(w, e);
		chk(exp_addr[15:0], crc16(e));
		close();
	endtask
	// Sends one block of eight random bytes after a token, then the busy tail.
	task automatic blk(input logic [7:0] tok);
		x(tok);
		repeat (8) begin
			w[7:0] = rnd();
			wq.push_back(w[7:0]);
			x(w[7:0]);
		end
		x(8'h00);
		x(8'h00);
		x(8'hFF);
		chk(b, `DRESP_OK);
		busy(0);
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	// Each received data byte is compared with the queue of bytes sent.
	always @(posedge clk) begin
		if (wr_valid_r === 1'b1) begin
			chk(wr_data_r, wq.size() > 0 ? wq.pop_front() : 9'h100);
			chk(wr_addr_r, exp_addr);
			chk(lock_data_r, exp_addr == 32'h0);
		end
		if (cmd_fwd_r === 1'b1)
			fwds++;
	end

	// Main sequence of scenarios.
	initial begin
		for (int i = 0; i < 256; i++)
			prot[i] = 1'b0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		init_active <= 1'b1;
		cmd(`CMD_OPCOND, 32'h0, 1'b0, 8'h01);
		for (int i = 3; i >= 0; i--) begin
			x(8'hFF);
			w[i * 8 +: 8] = b;
		end
		chk(w, `OCR_VALUE);
		close();
		@(posedge clk) init_active <= 1'b0;
		ext_status2 <= rnd();
		cmd(`CMD_STATUS, 32'h0, 1'b0, 8'h00);
		x(8'hFF);
		chk(b, ext_status2);
		close();
		done("op cond and status");
		for (int i = 26; i < 58; i++) begin
			if (i == 26 || i == 31 || (i >= 39 && i <= 41) || i >= 43) begin
				cmd(6'(i), 32'h0, 1'b0, 8'h04);
				close();
			end
		end
		done("illegal");
		cmd(`CMD_ERS_LAST, 32'h00050000, 1'b0, 8'h10);
		close();
		cmd(`CMD_ERS_FIRST, 32'h00020000, 1'b0, 8'h00);
		close();
		cmd(`CMD_OPCOND, 32'h0, 1'b0, 8'h02);
		close();
		cmd(`CMD_ERS_FIRST, 32'h00020000, 1'b0, 8'h00);
		close();
		cmd(`CMD_ERS_LAST, 32'h00050000, 1'b0, 8'h00);
		close();
		cmd(`CMD_ERASE, 32'h0, 1'b0, 8'h00);
		busy(0);
		close();
		chk(erase_first_r, 32'h00020000);
		chk(erase_last_r, 32'h00050000);
		done("erase");
		for (int g = 3; g < 256; g += 252) begin
			cmd(`CMD_PROT_SET, 32'(g) << 16, 1'b0, 8'h00);
			busy(0);
			close();
			prot[g] = 1'b1;
		end
		qry(2);
		qry(250);
		cmd(`CMD_PROT_CLR, 32'h00030000, 1'b0, 8'h00);
		busy(0);
		close();
		prot[3] = 1'b0;
		qry(2);
		cmd(`CMD_PROT_SET, 32'h02000000, 1'b0, 8'h40);
		close();
		done("protect");
		@(posedge clk) mem_busy <= 1'b1;
		cmd(`CMD_PROG_CSD, 32'h0, 1'b0, 8'h00);
		busy(5);
		close();
		cmd(`CMD_CRC_CTL, 32'h1, 1'b0, 8'h00);
		close();
		chk(crc_enable_r, 1'b1);
		cmd(`CMD_OPCOND, 32'h0, 1'b1, 8'h08);
		close();
		cmd(`CMD_CRC_CTL, 32'h0, 1'b0, 8'h00);
		close();
		chk(crc_enable_r, 1'b0);
		done("program and checksum");
		cmd(`CMD_WR_MULTI, 32'h10, 1'b0, 8'h20);
		close();
		@(posedge clk) blk_len_value <= 12'h008;
		blk_len_load <= 1'b1;
		@(posedge clk) blk_len_load <= 1'b0;
		exp_addr = 32'h10;
		cmd(`CMD_WR_MULTI, exp_addr, 1'b0, 8'h00);
		for (int k = 0; k < 2; k++) begin
			blk(`TOK_START_MULTI);
			exp_addr += 8;
		end
		x(`TOK_STOP);
		busy(0);
		close();
		chk(wq.size(), 0);
		done("multi write");
		exp_addr = 32'h0;
		cmd(`CMD_LOCK, 32'h0, 1'b0, 8'h00);
		blk(`TOK_START_SINGLE);
		close();
		@(posedge clk) preset_blocks <= 16'h0001;
		exp_addr = 32'h20;
		cmd(`CMD_WR_MULTI, exp_addr, 1'b0, 8'h00);
		blk(`TOK_START_MULTI);
		cmd(6'h10, 32'h8, 1'b0, 8'h00);
		close();
		chk(fwds, 1);
		chk(cmd_arg_r, 32'h8);
		chk(wq.size(), 0);
		done("lock and preset count");
		report_and_stop();
	end
endmodule // card_spi_cmd_response_unit_bench
